//--- hdl/byte_fifo_pkg.sv
// shared constants for the sampled-clock byte fifo
package byte_fifo_pkg;

  // ************************************************************
  // data path
  // ************************************************************
  localparam int          DATA_W        = 8;
  localparam int          DEPTH_DEFAULT = 256;   // 256 to 4096 allowed
  localparam int          DEPTH_MIN     = 256;
  localparam int          DEPTH_MAX     = 4096;
  localparam logic [7:0]  OUT_RESET     = 8'h00;

  // ************************************************************
  // flag reset levels
  // ************************************************************
  localparam logic        FULL_N_RESET  = 1'h1;  // not full
  localparam logic        EMPTY_N_RESET = 1'h0;  // empty

  // ************************************************************
  // pin sampling
  // ************************************************************
  localparam logic        PIN_LOW       = 1'h0;
  localparam logic        PIN_HIGH      = 1'h1;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int          CLK_PERIOD_PS          = 25000;
  localparam int          FLAG_CLOCK_SKEW_MIN_PS = 6000;
  localparam int          FLAG_CLOCK_SKEW_MIN_CYC =
    (FLAG_CLOCK_SKEW_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage : byte_fifo_pkg

//--- hdl/byte_store.sv
// storage array of the byte fifo with a registered read port
`timescale 1ns/1ps

module byte_store #(
  parameter int DEPTH = byte_fifo_pkg::DEPTH_DEFAULT,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              clear,
  input  wire logic                              wr_en,
  input  wire logic [AW-1:0]                     wr_addr,
  input  wire logic [byte_fifo_pkg::DATA_W-1:0]  wr_data,
  input  wire logic                              rd_en,
  input  wire logic [AW-1:0]                     rd_addr,
  output logic      [byte_fifo_pkg::DATA_W-1:0]  rd_data_reg
);

  // ************************************************************
  // array
  // ************************************************************
  logic [byte_fifo_pkg::DATA_W-1:0] mem [DEPTH];

  // write port, no reset on the array
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // output register: cleared by reset, held unless a read is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= byte_fifo_pkg::OUT_RESET;
    end else if (clear) begin
      rd_data_reg <= byte_fifo_pkg::OUT_RESET;
    end else if (rd_en) begin
      rd_data_reg <= mem[rd_addr];
    end
  end

endmodule : byte_store

//--- hdl/byte_fifo.sv
// byte fifo with separate write and read clock pins, sampled on clk
`timescale 1ns/1ps

module byte_fifo #(
  parameter int DEPTH = byte_fifo_pkg::DEPTH_DEFAULT
) (
  input  wire logic                              clk,
  input  wire logic                              arst_n,
  input  wire logic                              master_reset_n,
  input  wire logic                              write_clock,
  input  wire logic                              write_enable_n,
  input  wire logic [byte_fifo_pkg::DATA_W-1:0]  data_in,
  input  wire logic                              read_clock,
  input  wire logic                              read_enable_n,
  input  wire logic                              output_enable_n,
  output logic      [byte_fifo_pkg::DATA_W-1:0]  data_out,
  output logic                                   data_out_en,
  output logic                                   full_n,
  output logic                                   empty_n
);

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int AW  = $clog2(DEPTH);
  localparam int PW  = AW + 1;
  localparam int DW  = byte_fifo_pkg::DATA_W;
  localparam int NP  = DW + 6;           // sampled pin count

  // pointer with its wrap bit on top
  typedef logic [PW-1:0] ptr_t;

  // binary to gray, used on both sides
  function automatic ptr_t to_gray(input ptr_t b);
    to_gray = b ^ (b >> 1);
  endfunction : to_gray

  // ************************************************************
  // reset release
  // ************************************************************
  // first flop and released copy of the system reset
  logic rst_s1_reg;
  logic rst_n_reg;

  // async assert, two-flop release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= byte_fifo_pkg::PIN_LOW;
      rst_n_reg  <= byte_fifo_pkg::PIN_LOW;
    end else begin
      rst_s1_reg <= byte_fifo_pkg::PIN_HIGH;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  // ************************************************************
  // pin sampling
  // ************************************************************
  // idle levels the samplers reset to, so no false clock rise follows reset
  localparam logic [NP-1:0] PIN_RST = {byte_fifo_pkg::PIN_LOW, byte_fifo_pkg::PIN_LOW,
                                       byte_fifo_pkg::PIN_HIGH, byte_fifo_pkg::PIN_LOW,
                                       byte_fifo_pkg::PIN_HIGH, byte_fifo_pkg::PIN_HIGH,
                                       byte_fifo_pkg::OUT_RESET};

  logic [NP-1:0] pin_raw;
  logic [NP-1:0] pin_s1_reg;
  logic [NP-1:0] pin_s2_reg;

  assign pin_raw = {master_reset_n, write_clock, write_enable_n,
                    read_clock, read_enable_n, output_enable_n, data_in};

  // two flops per pin, one generate slice each
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_pin
      always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
          pin_s1_reg[gi] <= PIN_RST[gi];
          pin_s2_reg[gi] <= PIN_RST[gi];
        end else begin
          pin_s1_reg[gi] <= pin_raw[gi];
          pin_s2_reg[gi] <= pin_s1_reg[gi];
        end
      end
    end
  endgenerate

  logic          mrst_n_s;
  logic          wclk_s;
  logic          wen_n_s;
  logic          rclk_s;
  logic          ren_n_s;
  logic          oe_n_s;
  logic [DW-1:0] din_s;

  // second-flop copies are the only taps of the samplers
  assign {mrst_n_s, wclk_s, wen_n_s, rclk_s, ren_n_s, oe_n_s, din_s} = pin_s2_reg;

  // ************************************************************
  // clock edge detection
  // ************************************************************
  // delayed clock levels and one-cycle rise strobes
  logic wclk_d_reg;
  logic rclk_d_reg;
  logic clear;
  logic w_edge;
  logic r_edge;

  // previous clock levels; free-running clocks during reset are harmless
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wclk_d_reg <= byte_fifo_pkg::PIN_LOW;
      rclk_d_reg <= byte_fifo_pkg::PIN_LOW;
    end else begin
      wclk_d_reg <= wclk_s;
      rclk_d_reg <= rclk_s;
    end
  end

  // master reset level and rise strobes
  assign clear  = ~mrst_n_s;
  assign w_edge = wclk_s & ~wclk_d_reg;
  assign r_edge = rclk_s & ~rclk_d_reg;

  // ************************************************************
  // write side
  // ************************************************************
  ptr_t wr_bin_reg;
  ptr_t wr_gray_reg;
  ptr_t rq1_reg;
  ptr_t rq2_reg;
  logic full_n_reg;
  logic do_write;
  ptr_t wr_bin_next;
  ptr_t wr_gray_next;
  ptr_t full_mark;
  // read pointer declared early: its gray copy feeds the write-side sampler
  ptr_t rd_bin_reg;
  ptr_t rd_gray_reg;

  // write taken on a sampled rise with enable low and room left
  assign do_write     = w_edge & ~wen_n_s & full_n_reg;
  assign wr_bin_next  = do_write ? ptr_t'(wr_bin_reg + 1'b1) : wr_bin_reg;
  assign wr_gray_next = to_gray(wr_bin_next);
  // full when the write pointer laps the read pointer by depth
  assign full_mark    = {~rq2_reg[PW-1:PW-2], rq2_reg[PW-3:0]};

  // read pointer into the write side, two flops
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rq1_reg <= '0;
      rq2_reg <= '0;
    end else if (clear) begin
      rq1_reg <= '0;
      rq2_reg <= '0;
    end else begin
      rq1_reg <= rd_gray_reg;
      rq2_reg <= rq1_reg;
    end
  end

  // write pointer, advanced only on accepted writes
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wr_bin_reg  <= '0;
      wr_gray_reg <= '0;
    end else if (clear) begin
      wr_bin_reg  <= '0;
      wr_gray_reg <= '0;
    end else if (do_write) begin
      wr_bin_reg  <= wr_bin_next;
      wr_gray_reg <= wr_gray_next;
    end
  end

  // full flag, re-evaluated only at write-clock rises
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      full_n_reg <= byte_fifo_pkg::FULL_N_RESET;
    end else if (clear) begin
      full_n_reg <= byte_fifo_pkg::FULL_N_RESET;
    end else if (w_edge) begin
      full_n_reg <= ~(wr_gray_next == full_mark);
    end
  end

  // ************************************************************
  // read side
  // ************************************************************
  ptr_t wq1_reg;
  ptr_t wq2_reg;
  logic empty_n_reg;
  logic do_read;
  ptr_t rd_bin_next;
  ptr_t rd_gray_next;

  // read taken on a sampled rise with enable low and data present
  assign do_read      = r_edge & ~ren_n_s & empty_n_reg;
  assign rd_bin_next  = do_read ? ptr_t'(rd_bin_reg + 1'b1) : rd_bin_reg;
  assign rd_gray_next = to_gray(rd_bin_next);

  // write pointer into the read side, two flops
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wq1_reg <= '0;
      wq2_reg <= '0;
    end else if (clear) begin
      wq1_reg <= '0;
      wq2_reg <= '0;
    end else begin
      wq1_reg <= wr_gray_reg;
      wq2_reg <= wq1_reg;
    end
  end

  // read pointer, advanced only on accepted reads
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rd_bin_reg  <= '0;
      rd_gray_reg <= '0;
    end else if (clear) begin
      rd_bin_reg  <= '0;
      rd_gray_reg <= '0;
    end else if (do_read) begin
      rd_bin_reg  <= rd_bin_next;
      rd_gray_reg <= rd_gray_next;
    end
  end

  // empty flag, re-evaluated only at read-clock rises
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      empty_n_reg <= byte_fifo_pkg::EMPTY_N_RESET;
    end else if (clear) begin
      empty_n_reg <= byte_fifo_pkg::EMPTY_N_RESET;
    end else if (r_edge) begin
      empty_n_reg <= ~(rd_gray_next == wq2_reg);
    end
  end

  // ************************************************************
  // storage and output register
  // ************************************************************
  // array follows accepted writes, reads load the output register
  byte_store #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_store (
    .clk         (clk),
    .rst_n       (rst_n_reg),
    .clear       (clear),
    .wr_en       (do_write),
    .wr_addr     (wr_bin_reg[AW-1:0]),
    .wr_data     (din_s),
    .rd_en       (do_read),
    .rd_addr     (rd_bin_reg[AW-1:0]),
    .rd_data_reg (data_out)
  );

  // ************************************************************
  // output enable
  // ************************************************************
  // registered drive enable
  logic oe_reg;

  // drive enable follows the sampled output enable pin
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      oe_reg <= byte_fifo_pkg::PIN_LOW;
    end else begin
      oe_reg <= ~oe_n_s;
    end
  end

  // outputs straight from their flops
  assign data_out_en = oe_reg;
  assign full_n      = full_n_reg;
  assign empty_n     = empty_n_reg;

endmodule : byte_fifo

//--- dv/byte_fifo_checker.sv
// port assertions for the byte fifo
`timescale 1ns/1ps
module byte_fifo_checker #(
  parameter int DEPTH = byte_fifo_pkg::DEPTH_DEFAULT
) (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       master_reset_n,
  input wire logic       write_clock,
  input wire logic       write_enable_n,
  input wire logic [7:0] data_in,
  input wire logic       read_clock,
  input wire logic       read_enable_n,
  input wire logic       output_enable_n,
  input wire logic [7:0] data_out,
  input wire logic       data_out_en,
  input wire logic       full_n,
  input wire logic       empty_n
);
  // ********************
  // helper ages
  // ********************
  logic [3:0] wr_age_reg, rd_age_reg, mr_age_reg, rst_age_reg;
  logic       wclk_q_reg, rclk_q_reg;

  // cycles since pin clock rises, master reset and system reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_age_reg  <= 4'hF;
      rd_age_reg  <= 4'hF;
      mr_age_reg  <= 4'h0;
      rst_age_reg <= 4'h0;
      wclk_q_reg  <= 1'b0;
      rclk_q_reg  <= 1'b0;
    end else begin
      wclk_q_reg  <= write_clock;
      rclk_q_reg  <= read_clock;
      wr_age_reg  <= (write_clock && !wclk_q_reg) ? 4'h0 : wr_age_reg + {3'h0, wr_age_reg != 4'hF};
      rd_age_reg  <= (read_clock && !rclk_q_reg) ? 4'h0 : rd_age_reg + {3'h0, rd_age_reg != 4'hF};
      mr_age_reg  <= !master_reset_n ? 4'h0 : mr_age_reg + {3'h0, mr_age_reg != 4'hF};
      rst_age_reg <= rst_age_reg + {3'h0, rst_age_reg != 4'hF};
    end
  end

  // ********************
  // properties
  // ********************
  default clocking dc @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_mr_held; (!master_reset_n)[*5]; endsequence
  sequence s_ren_idle; read_enable_n[*4]; endsequence
  sequence s_oe_low; (!output_enable_n)[*4]; endsequence
  sequence s_oe_high; output_enable_n[*4]; endsequence
  property p_reset_clear; s_mr_held |-> full_n && !empty_n && data_out == 8'h00; endproperty
  property p_full_wclk; $changed(full_n) |-> wr_age_reg <= 4'h5 || mr_age_reg <= 4'h5; endproperty
  property p_empty_rclk; $changed(empty_n) |-> rd_age_reg <= 4'h5 || mr_age_reg <= 4'h5; endproperty
  property p_out_rclk; $changed(data_out) |-> rd_age_reg <= 4'h5 || mr_age_reg <= 4'h5; endproperty
  property p_hold_idle; s_ren_idle ##0 (mr_age_reg > 4'h6) |=> $stable(data_out); endproperty
  property p_hold_empty; !empty_n && mr_age_reg > 4'h6 |=> $stable(data_out); endproperty
  property p_oe_on; s_oe_low ##0 (rst_age_reg > 4'h8) |-> data_out_en; endproperty
  property p_oe_off; s_oe_high ##0 (rst_age_reg > 4'h8) |-> !data_out_en; endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");
  a_full_wclk: assert property (p_full_wclk) else $error("full flag moved off write clock");
  a_empty_rclk: assert property (p_empty_rclk) else $error("empty flag moved off read clock");
  a_out_rclk: assert property (p_out_rclk) else $error("output moved off read clock");
  a_hold_idle: assert property (p_hold_idle) else $error("output changed with read idle");
  a_hold_empty: assert property (p_hold_empty) else $error("output changed while empty");
  a_oe_on: assert property (p_oe_on) else $error("output not driven");
  a_oe_off: assert property (p_oe_off) else $error("output not released");
endmodule : byte_fifo_checker

//--- dv/fifo_far_side.sv
// producer and consumer pin model on the far side of the fifo
`timescale 1ns/1ps
module fifo_far_side (
  input  wire logic clk,
  output logic      write_clock,
  output logic      write_enable_n,
  output logic [7:0] data_in,
  output logic      read_clock,
  output logic      read_enable_n
);
  // ********************
  // pin pulses
  // ********************
  // idle pins at time zero
  initial begin
    write_clock = 1'b0;
    write_enable_n = 1'b1;
    data_in = 8'h00;
    read_clock = 1'b0;
    read_enable_n = 1'b1;
  end

  // one write clock pulse, enable and byte held around the rise
  task automatic wr_pulse(input logic en_n, input logic [7:0] d);
    @(posedge clk);
    write_enable_n <= en_n;
    data_in <= d;
    repeat (4) @(posedge clk);
    write_clock <= ~write_clock;
    repeat (4) @(posedge clk);
    write_clock <= ~write_clock;
    write_enable_n <= 1'b1;
    data_in <= ~d; // released bus shows no stale byte
    repeat (2) @(posedge clk);
  endtask : wr_pulse

  // one read clock pulse with enable held around the rise
  task automatic rd_pulse(input logic en_n);
    @(posedge clk);
    read_enable_n <= en_n;
    repeat (4) @(posedge clk);
    read_clock <= ~read_clock;
    repeat (4) @(posedge clk);
    read_clock <= ~read_clock;
    read_enable_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : rd_pulse
endmodule : fifo_far_side

//--- dv/tb_top.sv
// self-checking bench for the byte fifo
`timescale 1ns/1ps
module tb_top;
  localparam int DEPTH = 256;
  logic       clk, arst_n, master_reset_n, output_enable_n;
  logic       write_clock, write_enable_n, read_clock, read_enable_n;
  logic       data_out_en, full_n, empty_n;
  logic [7:0] data_in, data_out;
  wire  [7:0] q_bus;
  int         bad_count = 0;
  int         samples_checked = 0;
  int         cycle_count = 0;

  // ********************
  // harness
  // ********************
  // resolved output pins
  assign q_bus = data_out_en ? data_out : 8'hZZ;

  // free running system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  byte_fifo #(.DEPTH(DEPTH)) dut (
    .clk(clk), .arst_n(arst_n), .master_reset_n(master_reset_n), .write_clock(write_clock),
    .write_enable_n(write_enable_n), .data_in(data_in), .read_clock(read_clock),
    .read_enable_n(read_enable_n), .output_enable_n(output_enable_n), .data_out(data_out),
    .data_out_en(data_out_en), .full_n(full_n), .empty_n(empty_n));
  fifo_far_side far (
    .clk(clk), .write_clock(write_clock), .write_enable_n(write_enable_n), .data_in(data_in),
    .read_clock(read_clock), .read_enable_n(read_enable_n));

  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, seen, exp);
    end
  endtask : check

  // cuts a hang short
  always @(posedge clk) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 12000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ********************
  // scenarios
  // ********************
  task automatic t_reset_state();
    check({7'h00, full_n}, 8'h01);
    check({7'h00, empty_n}, 8'h00);
    check(q_bus, 8'h00);
    far.rd_pulse(1'b0);
    check(q_bus, 8'h00);
  endtask : t_reset_state

  task automatic t_single();
    far.wr_pulse(1'b0, 8'hA5);
    far.rd_pulse(1'b1);
    check({7'h00, empty_n}, 8'h01);
    check(q_bus, 8'h00);
    far.rd_pulse(1'b0);
    check(q_bus, 8'hA5);
    check({7'h00, empty_n}, 8'h00);
  endtask : t_single

  task automatic t_fill_drain();
    for (int i = 0; i < DEPTH; i++) begin
      far.wr_pulse(1'b0, 8'(i));
      check({7'h00, full_n}, (i == DEPTH - 1) ? 8'h00 : 8'h01);
    end
    far.wr_pulse(1'b0, 8'hEE);
    check({7'h00, full_n}, 8'h00);
    far.rd_pulse(1'b1);
    far.rd_pulse(1'b0);
    check(q_bus, 8'h00);
    far.wr_pulse(1'b1, 8'h00);
    check({7'h00, full_n}, 8'h01);
    far.wr_pulse(1'b0, 8'h5A);
    check({7'h00, full_n}, 8'h00);
    for (int i = 1; i <= DEPTH; i++) begin
      far.rd_pulse(1'b0);
      check(q_bus, (i == DEPTH) ? 8'h5A : 8'(i));
    end
    check({7'h00, empty_n}, 8'h00);
    far.rd_pulse(1'b0);
    check(q_bus, 8'h5A);
  endtask : t_fill_drain

  task automatic t_oe();
    output_enable_n <= ~output_enable_n;
    repeat (5) @(posedge clk);
    check(q_bus, 8'hZZ);
    output_enable_n <= ~output_enable_n;
    repeat (5) @(posedge clk);
    check(q_bus, 8'h5A);
  endtask : t_oe

  task automatic t_mreset();
    far.wr_pulse(1'b0, 8'h33);
    master_reset_n <= 1'b0;
    far.wr_pulse(1'b0, 8'h77);
    check(q_bus, 8'h00);
    check({7'h00, full_n}, 8'h01);
    check({7'h00, empty_n}, 8'h00);
    master_reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    far.wr_pulse(1'b0, 8'h42);
    far.rd_pulse(1'b1);
    far.rd_pulse(1'b0);
    check(q_bus, 8'h42);
  endtask : t_mreset

  // system reset in mid-run clears pointers, flags and output register
  task automatic t_arst();
    far.wr_pulse(1'b0, 8'h6C);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    check({7'h00, full_n}, 8'h01);
    check({7'h00, empty_n}, 8'h00);
    check(q_bus, 8'h00);
    far.rd_pulse(1'b0);
    check(q_bus, 8'h00);
    far.wr_pulse(1'b0, 8'h9C);
    far.rd_pulse(1'b1);
    far.rd_pulse(1'b0);
    check(q_bus, 8'h9C);
  endtask : t_arst

  // reset, then every scenario in turn
  initial begin
    arst_n = 1'b0;
    master_reset_n = 1'b0;
    output_enable_n = 1'b0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    master_reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_reset_state();
    t_single();
    t_fill_drain();
    t_oe();
    t_mreset();
    t_arst();
    print_verdict();
  end
endmodule : tb_top

bind byte_fifo byte_fifo_checker #(.DEPTH(DEPTH)) u_chk (
  .clk(clk), .arst_n(arst_n), .master_reset_n(master_reset_n), .write_clock(write_clock),
  .write_enable_n(write_enable_n), .data_in(data_in), .read_clock(read_clock),
  .read_enable_n(read_enable_n), .output_enable_n(output_enable_n), .data_out(data_out),
  .data_out_en(data_out_en), .full_n(full_n), .empty_n(empty_n));
